// *** rtl/wwd_pkg.sv ***
// Constants and types shared by the window watchdog files
package wwd_pkg;

   // ======================================================
   // Clock and timebase
   localparam int  CLK_PERIOD_NS = 50;
   localparam int  TICK_NS       = 1000;
   localparam int  TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   localparam int  TW            = 27;
   localparam int  RW            = 10;
   localparam int  PW            = 16;
   localparam real TICKS_PER_MS  = 1.0e6 / TICK_NS;

   // Milliseconds to whole timebase ticks
   function automatic logic [TW-1:0] ms_tk(input real ms);
      return TW'(int'(ms * TICKS_PER_MS));
   endfunction

   // ======================================================
   // Times
   localparam real INIT_US      = 381.0;
   localparam real STARTUP_US   = 300.0;
   localparam real SETTLE_US    = 150.0;
   localparam real HOLD_OPEN_MS = 200.0;
   localparam real HOLD_PULL_MS = 10.0;
   localparam int  OV_DEL_US    = 35;
   localparam int  UV_DEL_US    = 17;
   localparam logic [TW-1:0] INIT_TK = ms_tk(INIT_US / 1000.0);
   localparam logic [TW-1:0] STARTUP_TK = ms_tk(STARTUP_US / 1000.0);
   localparam logic [TW-1:0] SETTLE_TK = ms_tk(SETTLE_US / 1000.0);
   localparam logic [TW-1:0] HOLD_OPEN_TK = ms_tk(HOLD_OPEN_MS);
   localparam logic [TW-1:0] HOLD_PULL_TK = ms_tk(HOLD_PULL_MS);
   localparam logic [RW-1:0] OV_DEL_CYC =
      RW'(OV_DEL_US * 1000 / CLK_PERIOD_NS);
   localparam logic [RW-1:0] UV_DEL_CYC =
      RW'(UV_DEL_US * 1000 / CLK_PERIOD_NS);

   // Window bounds, strap open then strap pulled up
   localparam logic [TW-1:0] LO_OPEN_00 = ms_tk(22.5);
   localparam logic [TW-1:0] LO_OPEN_01 = ms_tk(1.85);
   localparam logic [TW-1:0] LO_OPEN_11 = ms_tk(800.0);
   localparam logic [TW-1:0] UP_OPEN_00 = ms_tk(55.0);
   localparam logic [TW-1:0] UP_OPEN_01 = ms_tk(27.5);
   localparam logic [TW-1:0] UP_OPEN_11 = ms_tk(1600.0);
   localparam logic [TW-1:0] LO_PULL_00 = ms_tk(9.0);
   localparam logic [TW-1:0] LO_PULL_01 = ms_tk(9.0);
   localparam logic [TW-1:0] LO_PULL_11 = ms_tk(1.85);
   localparam logic [TW-1:0] UP_PULL_00 = ms_tk(109.0);
   localparam logic [TW-1:0] UP_PULL_01 = ms_tk(195.0);
   localparam logic [TW-1:0] UP_PULL_11 = ms_tk(11.0);

   // Ratio shifts for capacitor timing
   localparam int SH_EIGHTH  = 3;
   localparam int SH_HALF    = 1;
   localparam int SH_QUARTER = 2;

   // ======================================================
   // Register map
   localparam int              AW            = 8;
   localparam logic [AW-1:0]   ADDR_STATUS   = 8'h00;
   localparam logic [AW-1:0]   ADDR_CAP_WIN  = 8'h04;
   localparam logic [AW-1:0]   ADDR_CAP_HOLD = 8'h08;
   localparam logic [TW-1:0]   CAP_WIN_RST   = ms_tk(62.74);
   localparam logic [TW-1:0]   CAP_HOLD_RST  = ms_tk(0.703);
   localparam int ST_RESET_BIT = 0;
   localparam int ST_FAULT_BIT = 1;
   localparam int ST_WDEN_BIT  = 2;
   localparam int ST_RS_LSB    = 4;
   localparam int ST_WD_LSB    = 8;
   localparam int ST_CFG_LSB   = 12;
   localparam int ST_SEL_LSB   = 16;

   // ======================================================
   // Types
   typedef enum logic [1:0] {
      SEL_1_8 = 2'b00,
      SEL_3_4 = 2'b01,
      SEL_OFF = 2'b10,
      SEL_1_2 = 2'b11
   } wwd_sel_t;

   typedef enum logic [1:0] {
      STRAP_OPEN = 2'b00,
      STRAP_PULL = 2'b01,
      STRAP_CAP  = 2'b10
   } wwd_strap_t;

   typedef enum logic [2:0] {
      RS_POWERUP = 3'b000,
      RS_FAULT   = 3'b001,
      RS_EVAL    = 3'b011,
      RS_HOLD    = 3'b010,
      RS_RUN     = 3'b110
   } wwd_rs_t;

   typedef enum logic [2:0] {
      WD_OFF    = 3'b000,
      WD_SETTLE = 3'b001,
      WD_CLOSED = 3'b011,
      WD_OPEN   = 3'b010,
      WD_TRIP   = 3'b110
   } wwd_wd_t;

   typedef struct packed {
      logic [1:0] wd;
      logic [1:0] rst;
   } wwd_cfg_t;

   typedef struct packed {
      logic       supply_ok;
      logic       rail_over;
      logic       rail_under;
      logic       sel_lo;
      logic       sel_hi;
      logic       kick;
      logic       reset_rb;
      logic       fault_rb;
      logic [1:0] wd_strap;
      logic [1:0] rst_strap;
   } wwd_pins_t;

   localparam int PIN_W = $bits(wwd_pins_t);

endpackage

// *** rtl/wwd_sync.sv ***
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module wwd_sync #(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   // ======================================================
   // Stages
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // First stage feeds only the second; a bit moves once two agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end
      else
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
      end
   end

endmodule
`default_nettype wire

// *** rtl/wwd_timer.sv ***
// Saturating counter of timebase ticks
`timescale 1ns/1ns
`default_nettype none

module wwd_timer #(
   parameter int W = 8
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clear,
   input  wire logic         tick,
   output logic [W-1:0]      count
);

   // ======================================================
   // Counter
   // Restart on clear, otherwise count ticks and stop at the top
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else if (clear)
         count <= '0;
      else if (tick && count != '1)
         count <= count + 1'b1;
   end

endmodule
`default_nettype wire

// *** rtl/wwd_top.sv ***
// Window watchdog and reset timing core with APB access
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RQ1] Strap pins are evaluated for 381 us before their setting is used
// [RQ2] Host spaces window select changes at least 500 us apart
// [RQ3] Host holds a new window select level 1 us before use
// [RQ4] Outputs follow the rail only after supply is good for 300 us
// [RQ5] Reset hold is 200 ms with delay strap open, 10 ms pulled up
// [RQ6] Reset reacts to overvoltage after 35 us, undervoltage after 17 us
// [RQ7] Capacitor timing uses ratios 1/8, 1/2 and 3/4 by select code
// [RQ8] With ratio 3/4 the open window may be empty
// [RQ9] Select code 10 disables the watchdog whatever the strap
// [RQ10] Lower bounds per select code and timing strap, from the table
// [RQ11] Upper bounds per select code and timing strap, from the table
// [RQ12] Kicks are ignored for 150 us after the watchdog is enabled
// [RQ13] Host drives each kick pulse for at least 50 ns; the filter only passes a low level that spans two clocks (100 ns)
// [RQ14] Reset is driven low whenever the supply is below lockout level
// [RQ15] Behaviour below the power-on supply level is not modelled
// [RQ16] A falling kick edge must land inside the window, else timeout
// [RQ17] Timeout drives fault low for hold time, only while reset is high
// [RQ18] Kicks are ignored while reset or fault is low, or when disabled
// [RQ19] Rail back in range starts the hold count, then reset releases; the code runs the 381 us strap evaluation before the hold
// [RQ20] Strap setting latched after evaluation; times from a prescaler
module wwd_top
   import wwd_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [AW-1:0] paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          supply_ok,
   input  wire logic          rail_over,
   input  wire logic          rail_under,
   input  wire logic          window_select_lo,
   input  wire logic          window_select_hi,
   input  wire logic          kick_input,
   input  wire logic [1:0]    watchdog_timing_strap,
   input  wire logic [1:0]    reset_delay_strap,
   input  wire logic          reset_out_n_i,
   output logic               reset_out_n_o,
   output logic               reset_out_n_oe,
   input  wire logic          watchdog_fault_out_n_i,
   output logic               watchdog_fault_out_n_o,
   output logic               watchdog_fault_out_n_oe
);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ======================================================
   // Pin synchronisers
   wwd_pins_t         pins_raw;
   logic [PIN_W-1:0]  pins_vec;
   wwd_pins_t         p;

   // A kick low level must span two clocks to pass the filter
   assign pins_raw = {supply_ok, rail_over, rail_under, window_select_lo,
                      window_select_hi, kick_input, reset_out_n_i,
                      watchdog_fault_out_n_i, watchdog_timing_strap,
                      reset_delay_strap}; // RQ13
   assign p = wwd_pins_t'(pins_vec);

   wwd_sync #(
      .W(PIN_W)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (pins_raw),
      .q     (pins_vec)
   );

   // ======================================================
   // Timebase
   logic [PW-1:0] pre_cnt;
   logic          tick;

   // One tick per microsecond
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt <= '0;
         tick    <= 1'b0;
      end
      else if (pre_cnt == PW'(TICK_CYCLES - 1))
      begin
         pre_cnt <= '0;
         tick    <= 1'b1; // RQ20
      end
      else
      begin
         pre_cnt <= pre_cnt + 1'b1;
         tick    <= 1'b0;
      end
   end

   // ======================================================
   // Rail fault filter
   logic [RW-1:0] rail_cnt;
   logic          rail_bad;
   logic          rail_trip;

   assign rail_bad  = p.rail_over | p.rail_under;
   assign rail_trip = p.rail_over ? (rail_cnt >= OV_DEL_CYC)
                                  : (rail_cnt >= UV_DEL_CYC); // RQ6

   // Count clocks while the rail stays out of range
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rail_cnt <= '0;
      else if (!rail_bad)
         rail_cnt <= '0;
      else if (!rail_trip)
         rail_cnt <= rail_cnt + 1'b1;
   end

   // ======================================================
   // Software registers
   logic [TW-1:0] cap_win;
   logic [TW-1:0] cap_hold;
   logic          wr_en;

   // Capacitor-strap window and hold times in ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_win  <= CAP_WIN_RST;
         cap_hold <= CAP_HOLD_RST;
      end
      else if (wr_en && paddr == ADDR_CAP_WIN)
         cap_win <= pwdata[TW-1:0];
      else if (wr_en && paddr == ADDR_CAP_HOLD)
         cap_hold <= pwdata[TW-1:0];
   end

   // ======================================================
   // Configuration
   wwd_rs_t       rs_state;
   wwd_rs_t       next_rs_state;
   wwd_cfg_t      cfg;
   wwd_sel_t      live_sel;
   wwd_sel_t      run_sel;
   logic          wd_en;
   logic [TW-1:0] hold_tk;
   logic [TW-1:0] win_lo;
   logic [TW-1:0] win_up;

   assign live_sel = wwd_sel_t'({p.sel_lo, p.sel_hi});
   assign wd_en    = (live_sel != SEL_OFF); // RQ9

   // Strap setting caught when evaluation completes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg <= '0;
      else if (rs_state == RS_EVAL && next_rs_state == RS_HOLD)
         cfg <= {p.wd_strap, p.rst_strap}; // RQ1 RQ20
   end

   // Select code follows the pins only in reset or while watchdog is off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_sel <= SEL_OFF;
      else if (rs_state != RS_RUN || wd_state == WD_OFF)
         run_sel <= live_sel; // RQ2 RQ3
   end

   // Reset hold time from the delay strap
   always_comb
   begin
      case (cfg.rst)
         STRAP_OPEN: hold_tk = HOLD_OPEN_TK; // RQ5
         STRAP_PULL: hold_tk = HOLD_PULL_TK; // RQ5
         default:    hold_tk = cap_hold;
      endcase
   end

   // Window bounds from timing strap and select code
   always_comb
   begin
      win_lo = '0;
      win_up = cap_win;
      case ({cfg.wd, run_sel})
         {STRAP_OPEN, SEL_1_8}:
         begin
            win_lo = LO_OPEN_00; // RQ10
            win_up = UP_OPEN_00; // RQ11
         end
         {STRAP_OPEN, SEL_3_4}:
         begin
            win_lo = LO_OPEN_01; // RQ10
            win_up = UP_OPEN_01; // RQ11
         end
         {STRAP_OPEN, SEL_1_2}:
         begin
            win_lo = LO_OPEN_11; // RQ10
            win_up = UP_OPEN_11; // RQ11
         end
         {STRAP_PULL, SEL_1_8}:
         begin
            win_lo = LO_PULL_00; // RQ10
            win_up = UP_PULL_00; // RQ11
         end
         {STRAP_PULL, SEL_3_4}:
         begin
            win_lo = LO_PULL_01; // RQ10
            win_up = UP_PULL_01; // RQ11
         end
         {STRAP_PULL, SEL_1_2}:
         begin
            win_lo = LO_PULL_11; // RQ10
            win_up = UP_PULL_11; // RQ11
         end
         default:
         begin
            case (run_sel)
               SEL_1_8: win_lo = cap_win >> SH_EIGHTH; // RQ7
               SEL_1_2: win_lo = cap_win >> SH_HALF; // RQ7
               default: win_lo = cap_win - (cap_win >> SH_QUARTER); // RQ7 RQ8
            endcase
         end
      endcase
   end

   a_cap_ratio: assert property (cfg.wd == STRAP_CAP && run_sel == SEL_1_8
      |-> win_lo == (win_up >> SH_EIGHTH)) // RQ7
      else $error("capacitor ratio 1/8 not applied");

   // ======================================================
   // Reset sequencer
   logic [TW-1:0] rs_cnt;
   logic          rs_clear;

   assign rs_clear = (next_rs_state != rs_state) || !p.supply_ok;

   wwd_timer #(
      .W(TW)
   ) u_rs_timer (
      .clk   (pclk),
      .rst_n (presetn),
      .clear (rs_clear),
      .tick  (tick),
      .count (rs_cnt)
   );

   // Power-up, out of range, strap evaluation, hold, running
   always_comb
   begin
      next_rs_state = rs_state;
      if (!p.supply_ok)
         next_rs_state = RS_POWERUP; // RQ14 RQ15
      else
         case (rs_state)
            RS_POWERUP:
               if (rs_cnt > STARTUP_TK)
                  next_rs_state = RS_FAULT; // RQ4
            RS_FAULT:
               if (!rail_bad)
                  next_rs_state = RS_EVAL; // RQ19
            RS_EVAL:
               if (rail_bad)
                  next_rs_state = RS_FAULT;
               else if (rs_cnt > INIT_TK)
                  next_rs_state = RS_HOLD; // RQ1
            RS_HOLD:
               if (rail_bad)
                  next_rs_state = RS_FAULT;
               else if (rs_cnt >= hold_tk)
                  next_rs_state = RS_RUN; // RQ19 RQ5
            RS_RUN:
               if (rail_trip)
                  next_rs_state = RS_FAULT; // RQ6
            default:
               next_rs_state = RS_POWERUP;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rs_state <= RS_POWERUP;
      else
         rs_state <= next_rs_state;
   end

   a_startup_wait: assert property (rs_state == RS_POWERUP
      && next_rs_state == RS_FAULT |-> rs_cnt > STARTUP_TK) // RQ4
      else $error("left power-up before startup delay");
   a_eval_time: assert property (rs_state == RS_EVAL
      && next_rs_state == RS_HOLD |-> rs_cnt > INIT_TK) // RQ1
      else $error("strap evaluation cut short");
   a_hold_release: assert property (rs_state == RS_HOLD
      && next_rs_state == RS_RUN |=> !reset_out_n_oe
      && $past(rs_cnt) >= $past(hold_tk)) // RQ19
      else $error("reset released before hold time");
   a_uvlo_reset: assert property (!p.supply_ok
      |=> reset_out_n_oe && rs_state == RS_POWERUP) // RQ14
      else $error("reset not driven under lockout");
   a_rail_delay: assert property (rs_state == RS_RUN && p.supply_ok
      && next_rs_state == RS_FAULT |-> rail_cnt >= UV_DEL_CYC) // RQ6
      else $error("rail fault taken without delay");

   // ======================================================
   // Watchdog sequencer
   wwd_wd_t       wd_state;
   wwd_wd_t       next_wd_state;
   logic [TW-1:0] wd_cnt;
   logic          wd_clear;
   logic          kick_prev;
   logic          kick_fall;
   logic          kick_ok;

   // Falling kick edge counts only with both output pins high
   assign kick_fall = kick_prev & ~p.kick;
   assign kick_ok   = kick_fall & p.reset_rb & p.fault_rb; // RQ18

   // Window time keeps running from closed into open
   assign wd_clear = (next_wd_state != wd_state)
                     && !(wd_state == WD_CLOSED && next_wd_state == WD_OPEN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         kick_prev <= 1'b0;
      else
         kick_prev <= p.kick;
   end

   wwd_timer #(
      .W(TW)
   ) u_wd_timer (
      .clk   (pclk),
      .rst_n (presetn),
      .clear (wd_clear),
      .tick  (tick),
      .count (wd_cnt)
   );

   // Off, settling, window closed, window open, fault hold
   always_comb
   begin
      next_wd_state = wd_state;
      if (next_rs_state != RS_RUN || !wd_en)
         next_wd_state = WD_OFF; // RQ9 RQ17 RQ18
      else
         case (wd_state)
            WD_OFF:
               next_wd_state = WD_SETTLE;
            WD_SETTLE:
               if (wd_cnt > SETTLE_TK)
                  next_wd_state = WD_CLOSED; // RQ12
            WD_CLOSED:
               if (kick_ok)
                  next_wd_state = WD_TRIP; // RQ16
               else if (wd_cnt > win_lo)
                  next_wd_state = WD_OPEN; // RQ16
            WD_OPEN:
               if (kick_ok)
                  next_wd_state = WD_CLOSED; // RQ16
               else if (wd_cnt >= win_up)
                  next_wd_state = WD_TRIP; // RQ16
            WD_TRIP:
               if (wd_cnt >= hold_tk)
                  next_wd_state = WD_CLOSED; // RQ17
            default:
               next_wd_state = WD_OFF;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wd_state <= WD_OFF;
      else
         wd_state <= next_wd_state;
   end

   a_disable_off: assert property (p.supply_ok && !wd_en
      |=> wd_state == WD_OFF && !watchdog_fault_out_n_oe) // RQ9
      else $error("watchdog still active when disabled");
   a_settle_ignore: assert property (wd_state == WD_SETTLE
      |=> wd_state != WD_TRIP) // RQ12
      else $error("kick acted on during settle time");
   a_early_kick: assert property (wd_state == WD_CLOSED && kick_ok
      && next_rs_state == RS_RUN && wd_en |=> ##1 watchdog_fault_out_n_oe)
      // RQ16
      else $error("early kick did not trip");
   a_fault_hold: assert property (wd_state == WD_TRIP
      && next_wd_state == WD_CLOSED |-> wd_cnt >= hold_tk) // RQ17
      else $error("fault released before hold time");

   // ======================================================
   // Output pins
   // Open-drain pins: enable high pulls the line low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_out_n_o           <= 1'b0;
         reset_out_n_oe          <= 1'b1;
         watchdog_fault_out_n_o  <= 1'b0;
         watchdog_fault_out_n_oe <= 1'b0;
      end
      else
      begin
         reset_out_n_o           <= 1'b0;
         reset_out_n_oe          <= (next_rs_state != RS_RUN); // RQ19
         watchdog_fault_out_n_o  <= 1'b0;
         watchdog_fault_out_n_oe <= (next_wd_state == WD_TRIP); // RQ17
      end
   end

   a_fault_only_run: assert property (watchdog_fault_out_n_oe
      |-> !reset_out_n_oe) // RQ17
      else $error("fault asserted while reset low");

   // ======================================================
   // APB slave
   logic        setup;
   logic        hit;
   logic [31:0] rd_val;
   logic [31:0] status;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite & ~pslverr;

   // Status word shows pins and both sequencers
   always_comb
   begin
      status = '0;
      status[ST_RESET_BIT] = reset_out_n_oe;
      status[ST_FAULT_BIT] = watchdog_fault_out_n_oe;
      status[ST_WDEN_BIT]  = wd_en;
      status[ST_RS_LSB +: $bits(wwd_rs_t)]   = rs_state;
      status[ST_WD_LSB +: $bits(wwd_wd_t)]   = wd_state;
      status[ST_CFG_LSB +: $bits(wwd_cfg_t)] = cfg;
      status[ST_SEL_LSB +: $bits(wwd_sel_t)] = run_sel;
   end

   // Address decode, unmapped words answer with an error
   always_comb
   begin
      hit    = 1'b1;
      rd_val = '0;
      case (paddr)
         ADDR_STATUS:   rd_val = status;
         ADDR_CAP_WIN:  rd_val = 32'(cap_win);
         ADDR_CAP_HOLD: rd_val = 32'(cap_hold);
         default:       hit = 1'b0;
      endcase
   end

   // Answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
      end
   end

   c_reset_release: cover property (rs_state == RS_HOLD
      ##1 rs_state == RS_RUN);
   c_good_kick: cover property (wd_state == WD_OPEN
      ##1 wd_state == WD_CLOSED);
   c_late_trip: cover property (wd_state == WD_OPEN ##1 wd_state == WD_TRIP);
   c_apb_write: cover property (wr_en && paddr == ADDR_CAP_WIN);

endmodule
`default_nettype wire

// *** verif/wwd_host.sv ***
// Host model that kicks the watchdog
`timescale 1ns/1ns
`default_nettype none

module wwd_host
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [15:0] period,
   output logic             kick_input
);
   logic [15:0] cnt;
   logic [15:0] last;
   logic        fire;
   logic        fire_d;

   assign fire = (period != 16'h0) && (cnt == period - 16'h1);

   // Two low clocks each period, none at period 0
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt        <= 16'h0;
         last       <= 16'h0;
         fire_d     <= 1'b0;
         kick_input <= 1'b1;
      end
      else
      begin
         last       <= period;
         cnt        <= (period != last || fire) ? 16'h0 : cnt + 16'h1;
         fire_d     <= fire;
         kick_input <= !(fire || fire_d);
      end
   end
endmodule

`default_nettype wire

// *** verif/wwd_top_tb.sv ***
// Self-checking bench for the window watchdog
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, x) \
   begin \
      total_checks++; \
      if ((g) !== (x)) \
      begin \
         n_fail++; \
         $display("[ERR] %0t got %h exp %h", $time, g, x); \
      end \
   end

module wwd_top_tb
   import wwd_pkg::*;
;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic          pwrite = 0, pready, pslverr, e;
   logic [AW-1:0] paddr = '0;
   logic [31:0]   pwdata = '0, prdata, r;
   logic          s_lo = 0, s_hi = 0, r_ov = 0, r_un = 0, kick;
   logic          rst_oe, flt_oe;
   logic [15:0]   period = '0;
   int            n_fail = 0, total_checks = 0, cyc = 0, t0, n;

   // ==========
   // Clock, wires, timeout
   initial forever #25 pclk = ~pclk;

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         n_fail++;
         stop_test();
      end
   end

   wwd_top #(.TICK_CYCLES(1)) uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_ok(1'b1), .rail_over(r_ov), .rail_under(r_un),
      .window_select_lo(s_lo), .window_select_hi(s_hi),
      .kick_input(kick), .watchdog_timing_strap(2'b10),
      .reset_delay_strap(2'b10), .reset_out_n_i(!rst_oe),
      .reset_out_n_o(), .reset_out_n_oe(rst_oe),
      .watchdog_fault_out_n_i(!flt_oe), .watchdog_fault_out_n_o(),
      .watchdog_fault_out_n_oe(flt_oe));

   wwd_host host (.pclk(pclk), .presetn(presetn), .period(period),
      .kick_input(kick));

   // ==========
   // Tasks
   task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(negedge pclk);
      while (pready !== 1'b1)
         @(negedge pclk);
      r = prdata;
      e = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles until a pin enable reaches v, capped at lim
   task wait_for(input int s, input logic v, input int lim);
      n = 0;
      while (n < lim && (s ? flt_oe : rst_oe) !== v)
      begin
         @(negedge pclk);
         n++;
      end
   endtask

   task stop_test;
      if (n_fail == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========
   // Main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t0 = cyc;
      apb(0, ADDR_CAP_WIN, 0);
      `CHK(r, 32'(CAP_WIN_RST))
      apb(0, ADDR_CAP_HOLD, 0);
      `CHK(r, 32'(CAP_HOLD_RST))
      apb(1, ADDR_CAP_HOLD, 32'd200);
      apb(1, ADDR_CAP_WIN, 32'd800);
      apb(0, ADDR_CAP_HOLD, 0);
      `CHK(r, 32'd200)
      apb(0, 8'h0c, 0);
      `CHK({e, r}, 33'h100000000)
      wait_for(0, 1'b0, 1500);
      `CHK((cyc - t0) inside {[881:900]}, 1'b1)
      `CHK(flt_oe, 1'b0)
      @(posedge pclk);
      period <= 16'd400;
      wait_for(1, 1'b1, 3000);
      `CHK(n, 3000)
      @(posedge pclk);
      period <= 16'd0;
      wait_for(1, 1'b1, 1000);
      `CHK(n inside {[400:810]}, 1'b1)
      wait_for(1, 1'b0, 400);
      `CHK(n inside {[195:210]}, 1'b1)
      @(posedge pclk);
      period <= 16'd50;
      wait_for(1, 1'b1, 200);
      `CHK(n inside {[45:65]}, 1'b1)
      wait_for(1, 1'b0, 400);
      // Disable, then re-enable at ratio 3/4 after a long gap
      @(posedge pclk);
      s_lo <= 1'b1;
      wait_for(1, 1'b1, 1000);
      `CHK(n, 1000)
      @(posedge pclk);
      s_lo   <= 1'b0;
      s_hi   <= 1'b1;
      period <= 16'd760;
      wait_for(1, 1'b1, 3000);
      `CHK(n, 3000)
      @(posedge pclk);
      period <= 16'd0;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge pclk);
         r_ov <= (i == 0);
         r_un <= (i == 1);
         wait_for(0, 1'b1, 1000);
         `CHK(n inside {[(i ? 340 : 700):(i ? 352 : 712)]}, 1'b1)
         `CHK(flt_oe, 1'b0)
         @(posedge pclk);
         r_ov <= 1'b0;
         r_un <= 1'b0;
         wait_for(0, 1'b0, 1000);
         `CHK(n inside {[581:600]}, 1'b1)
      end
      stop_test();
   end
endmodule

`default_nettype wire
